// file: hw/nvmus_pkg.sv
// Shared constants and types for the flash unlock sequencer
package nvmus_pkg;

	// ----------------------------------------------------------------
	// Core write targets
	// ----------------------------------------------------------------
	localparam logic [1:0] TGT_OTHER = 2'h0;
	localparam logic [1:0] TGT_CTRL = 2'h1;
	localparam logic [1:0] TGT_KEY = 2'h2;

	// ----------------------------------------------------------------
	// Unlock keys and sequence timing
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// Spare instruction cycles allowed between two steps (next key load)
	localparam logic [1:0] SEQ_GAP_MAX = 2'h1;
	localparam logic [1:0] GAP_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Flash control register layout
	// ----------------------------------------------------------------
	localparam int CTRL_WR_BIT = 0;
	localparam int CTRL_ENABLE_BIT = 1;
	localparam int CTRL_OP_LSB = 2;
	localparam int CTRL_OP_MSB = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'h0F;

	// ----------------------------------------------------------------
	// Operation kinds carried in the control register
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_ROW_ERASE = 2'h0;
	localparam logic [1:0] OP_LATCH_LOAD = 2'h1;
	localparam logic [1:0] OP_LATCH_COMMIT = 2'h2;
	localparam logic [1:0] OP_USERID_COMMIT = 2'h3;

	// One register write issued by the core
	typedef struct packed {
		logic en;
		logic [1:0] tgt;
		logic [7:0] data;
	} nvmus_wr_t;

endpackage : nvmus_pkg

// file: hw/nvmus_key_seq.sv
// Unlock key sequence tracker
`timescale 1ns/1ns
module nvmus_key_seq import nvmus_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire nvmus_wr_t core_wr,
	input wire logic instr_ret,
	input wire logic irq_taken,
	output logic unlocked
);

	typedef enum logic [1:0] {S_IDLE, S_KEY1, S_KEY2} nvmus_seq_t;

	nvmus_seq_t state_r, state_nxt;
	logic [1:0] gap_r, gap_nxt;
	logic key_wr;

	// ----------------------------------------------------------------
	// Sequence next state
	// ----------------------------------------------------------------
	// Only register effects are watched, never opcodes
	always_comb begin
		state_nxt = state_r;
		gap_nxt = gap_r;
		key_wr = core_wr.en && (core_wr.tgt == TGT_KEY);
		if (irq_taken) begin
			state_nxt = S_IDLE; // Interrupt breaks the order
			gap_nxt = GAP_RESET;
		end else if (core_wr.en) begin
			gap_nxt = GAP_RESET;
			if (key_wr && core_wr.data == KEY_FIRST) begin
				state_nxt = S_KEY1; // First key
			end else if (key_wr && core_wr.data == KEY_SECOND &&
					state_r == S_KEY1) begin
				state_nxt = S_KEY2; // Second key right after first
			end else begin
				state_nxt = S_IDLE; // Any other write ends it
			end
		end else if (instr_ret && state_r != S_IDLE) begin
			if (gap_r == SEQ_GAP_MAX) begin
				state_nxt = S_IDLE; // Too many cycles between steps
				gap_nxt = GAP_RESET;
			end else begin
				gap_nxt = gap_r + 2'h1;
			end
		end
	end

	// Sequence registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= S_IDLE;
			gap_r <= GAP_RESET;
		end else begin
			state_r <= state_nxt;
			gap_r <= gap_nxt;
		end
	end

	assign unlocked = (state_r == S_KEY2);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_key2_entry: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_KEY2 && $past(state_r) != S_KEY2) |->
		($past(state_r) == S_KEY1 && $past(key_wr) &&
		$past(core_wr.data) == KEY_SECOND))
		else $error("second key stage entered without first key");

	chk_irq_abort: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		irq_taken |=> state_r == S_IDLE)
		else $error("interrupt did not abort the unlock sequence");

	chk_gap_abort: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r != S_IDLE && !core_wr.en && instr_ret ##1
		!core_wr.en && instr_ret) |=> state_r == S_IDLE)
		else $error("sequence survived two idle instruction cycles");

endmodule : nvmus_key_seq

// file: hw/nvmus_unlock_sequencer.sv
// Flash unlock sequencer: control register, trigger and core stall
// Notes on behaviour
// - Erase, latch load or commits start only after a full unbroken unlock.
// - Setting the trigger bit after both keys, with the enable bit already set, starts the operation.
// - Extra writes, interrupts or more than one spare cycle between steps reject it.
// - Core is stalled from trigger until the flash operation completes.
// - No idle instructions needed; the next instruction runs after stall.
// - Steps are recognised by register writes alone, not by opcode.
`timescale 1ns/1ns
module nvmus_unlock_sequencer import nvmus_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire nvmus_wr_t core_wr,
	input wire logic instr_ret,
	input wire logic irq_taken,
	input wire logic flash_done,
	output logic core_stall,
	output logic flash_start,
	output logic [1:0] flash_op,
	output logic [7:0] ctrl_rd
);

	typedef enum logic {O_IDLE, O_BUSY} nvmus_op_state_t;

	nvmus_op_state_t op_state_r, op_state_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic stall_r, stall_nxt;
	logic start_r, start_nxt;
	logic [1:0] op_r, op_nxt;
	logic unlocked;
	logic ctrl_wr;
	logic trig_req;
	logic launch;

	// ----------------------------------------------------------------
	// Key sequence tracker
	// ----------------------------------------------------------------
	nvmus_key_seq u_key_seq (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.core_wr(core_wr),
		.instr_ret(instr_ret),
		.irq_taken(irq_taken),
		.unlocked(unlocked)
	);

	// ----------------------------------------------------------------
	// Trigger decode
	// ----------------------------------------------------------------
	// Launch needs both keys, the enable bit and an idle array
	always_comb begin
		ctrl_wr = core_wr.en && (core_wr.tgt == TGT_CTRL);
		trig_req = ctrl_wr && core_wr.data[CTRL_WR_BIT];
		launch = trig_req && unlocked &&
			ctrl_r[CTRL_ENABLE_BIT] &&
			(op_state_r == O_IDLE);
	end

	// ----------------------------------------------------------------
	// Control register and operation next state
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		op_state_nxt = op_state_r;
		stall_nxt = stall_r;
		start_nxt = 1'b0;
		op_nxt = op_r;
		unique case (op_state_r)
			O_IDLE: begin
				if (ctrl_wr) begin
					// Trigger bit only sticks when the launch is legal
					ctrl_nxt = core_wr.data & CTRL_MASK;
					ctrl_nxt[CTRL_WR_BIT] = launch;
				end
				if (launch) begin
					op_state_nxt = O_BUSY;
					start_nxt = 1'b1;
					stall_nxt = 1'b1; // Hold the core from next cycle
					op_nxt = core_wr.data[CTRL_OP_MSB:CTRL_OP_LSB];
				end
			end
			O_BUSY: begin
				// Core is held; a control write arriving while busy is ignored, though key writes still reach the key tracker
				if (flash_done) begin
					op_state_nxt = O_IDLE;
					stall_nxt = 1'b0; // Release onto next instruction
					ctrl_nxt[CTRL_WR_BIT] = 1'b0;
				end
			end
		endcase
	end

	// Operation registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_state_r <= O_IDLE;
			ctrl_r <= CTRL_RESET;
			stall_r <= 1'b0;
			start_r <= 1'b0;
			op_r <= OP_ROW_ERASE;
		end else begin
			op_state_r <= op_state_nxt;
			ctrl_r <= ctrl_nxt;
			stall_r <= stall_nxt;
			start_r <= start_nxt;
			op_r <= op_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign core_stall = stall_r;
	assign flash_start = start_r;
	assign flash_op = op_r;
	assign ctrl_rd = ctrl_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_start_unlocked: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		flash_start |-> ($past(unlocked) &&
		$past(ctrl_r[CTRL_ENABLE_BIT]) && $past(trig_req)))
		else $error("flash start without full unlock");

	chk_enable_gate: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(trig_req && !ctrl_r[CTRL_ENABLE_BIT]) |=>
		(!flash_start && !ctrl_r[CTRL_WR_BIT]))
		else $error("trigger honoured with enable bit clear");

	chk_trigger_start: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(trig_req && unlocked && ctrl_r[CTRL_ENABLE_BIT] &&
		!core_stall) |=>
		(flash_start && core_stall && ctrl_r[CTRL_WR_BIT]))
		else $error("legal trigger did not start the operation");

	chk_start_pulse: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		flash_start |=> !flash_start)
		else $error("flash start longer than one cycle");

	chk_stall_hold: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(core_stall && !flash_done) |=> core_stall)
		else $error("stall dropped before flash completion");

	chk_stall_release: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(core_stall && flash_done) |=>
		(!core_stall && !ctrl_r[CTRL_WR_BIT]))
		else $error("stall not released one cycle after completion");

	chk_no_key_start: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(trig_req && !unlocked) |=> !flash_start [*2])
		else $error("trigger accepted without key sequence");

	chk_op_kind: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		flash_start |-> (flash_op ==
		$past(core_wr.data[CTRL_OP_MSB:CTRL_OP_LSB])))
		else $error("operation kind differs from triggering write");

	// ----------------------------------------------------------------
	// Checks on the busy phase
	// ----------------------------------------------------------------
	// Trigger bit reads back set exactly while the core is held
	chk_trigger_image: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		ctrl_rd[CTRL_WR_BIT] == core_stall)
		else $error("trigger bit image differs from stall state");

	// A stall only begins together with a start pulse
	chk_stall_entry: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(core_stall) |-> flash_start)
		else $error("stall raised without a flash start");

	// One operation at a time: no start while the array is busy
	chk_single_op: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		core_stall |=> !flash_start)
		else $error("second operation started while busy");

	// Writes arriving while held leave the register untouched
	chk_busy_frozen: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(core_stall && !flash_done) |=> $stable(ctrl_rd))
		else $error("control register changed while held");

	// Operation kind stays put for the whole busy phase
	chk_op_steady: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(core_stall && !flash_start) |-> $stable(flash_op))
		else $error("operation kind changed while busy");

	// A completion pulse seen while idle changes nothing
	chk_stray_done: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(!core_stall && flash_done && !ctrl_wr) |=>
		(!core_stall && $stable(ctrl_rd)))
		else $error("idle completion pulse disturbed the block");

	// An interrupt leaves no unlock for the write after it
	chk_irq_no_start: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		irq_taken |-> ##2 !flash_start)
		else $error("start followed an interrupted sequence");

	// The write held over the stall lands on the first free edge
	chk_free_after: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		($fell(core_stall) && ctrl_wr) |=>
		(ctrl_rd[CTRL_OP_MSB:CTRL_ENABLE_BIT] ==
		$past(core_wr.data[CTRL_OP_MSB:CTRL_ENABLE_BIT])))
		else $error("write after the stall was not taken");

endmodule : nvmus_unlock_sequencer

// file: bench/nvmus_flash_model.sv
// Flash array model that answers each start with a done pulse
`timescale 1ns/1ns
module nvmus_flash_model (
	input wire logic sys_clk,
	input wire logic flash_start,
	input wire logic [7:0] busy_cycles,
	output logic flash_done
);
	// Done pulse a chosen number of cycles after each start
	initial begin
		flash_done = 1'b0;
		forever begin
			@(posedge sys_clk iff flash_start);
			repeat (busy_cycles) @(negedge sys_clk);
			flash_done = 1'b1;
			@(negedge sys_clk);
			flash_done = 1'b0;
		end
	end
endmodule : nvmus_flash_model

// file: bench/nvm_unlock_sequencer_tb.sv
// Self-checking bench for the flash unlock sequencer
`timescale 1ns/1ns
module nvm_unlock_sequencer_tb import nvmus_pkg::*; ;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	nvmus_wr_t core_wr = '0;
	logic instr_ret = 1'b0;
	logic irq_taken = 1'b0;
	logic flash_done;
	logic core_stall;
	logic flash_start;
	logic [1:0] flash_op;
	logic [7:0] ctrl_rd;
	logic [7:0] busy = 8'h01;
	int bad_count = 0;
	int compares = 0;

	// ------------------------------------------------------------
	// Clock, design and flash model
	// ------------------------------------------------------------
	always #4 sys_clk = ~sys_clk;

	nvmus_unlock_sequencer nvmus_unlock_sequencer_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .core_wr(core_wr),
		.instr_ret(instr_ret), .irq_taken(irq_taken),
		.flash_done(flash_done), .core_stall(core_stall),
		.flash_start(flash_start), .flash_op(flash_op), .ctrl_rd(ctrl_rd));

	nvmus_flash_model nvmus_flash_model_inst (
		.sys_clk(sys_clk), .flash_start(flash_start),
		.busy_cycles(busy), .flash_done(flash_done));

	// ------------------------------------------------------------
	// Driving, comparing and closing
	// ------------------------------------------------------------
	task automatic drv(input logic e, input logic [1:0] t,
		input logic [7:0] d, input logic r, input logic q);
		@(negedge sys_clk);
		core_wr = '{e, t, d};
		instr_ret = r;
		irq_taken = q;
	endtask : drv

	task automatic idle;
		drv(1'b0, TGT_OTHER, 8'h00, 1'b0, 1'b0);
	endtask : idle

	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic end_sim;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Full sequence with gap cycles, optional interrupt, judged after
	task automatic unlock(input logic [1:0] op, input int gaps,
		input logic brk, input logic pre_en, input logic ok);
		int n;
		n = 0;
		drv(1'b1, TGT_CTRL, pre_en ? 8'h02 : 8'h00, 1'b0, 1'b0);
		drv(1'b1, TGT_KEY, KEY_FIRST, 1'b0, 1'b0);
		for (int i = 0; i < gaps; i++)
			drv(1'b0, TGT_OTHER, 8'h00, 1'b1, brk);
		drv(1'b1, TGT_KEY, KEY_SECOND, 1'b0, 1'b0);
		drv(1'b1, TGT_CTRL, {4'h0, op, 2'b11}, 1'b0, 1'b0);
		idle();
		chk({7'h00, ok}, {7'h00, flash_start});
		chk({7'h00, ok}, {7'h00, core_stall});
		chk({4'h0, op, 1'b1, ok}, ctrl_rd);
		if (ok) begin
			chk({6'h00, op}, {6'h00, flash_op});
			idle();
			chk(8'h00, {7'h00, flash_start});
			// Next instruction's write is held until the stall ends
			while (core_stall === 1'b1 && n < 100) begin
				drv(1'b1, TGT_CTRL, 8'h02, 1'b0, 1'b0);
				n++;
			end
			chk(8'h00, {7'h00, core_stall});
			chk({4'h0, op, 2'b10}, ctrl_rd);
			idle();
			chk(8'h02, ctrl_rd);
		end
	endtask : unlock

	// Every operation kind, prompt and slow flash, with and without gap
	task automatic t_ops;
		for (int k = 0; k < 4; k++) begin
			busy = k[0] ? 8'h14 : 8'h01;
			unlock(k[1:0], k % 2, 1'b0, 1'b1, 1'b1);
		end
	endtask : t_ops

	// Key written in reverse order, then a stray write between keys
	task automatic t_order;
		drv(1'b1, TGT_CTRL, 8'h02, 1'b0, 1'b0);
		drv(1'b1, TGT_KEY, KEY_SECOND, 1'b0, 1'b0);
		drv(1'b1, TGT_CTRL, 8'h07, 1'b0, 1'b0);
		idle();
		chk(8'h00, {7'h00, flash_start});
		drv(1'b1, TGT_KEY, KEY_FIRST, 1'b0, 1'b0);
		drv(1'b1, TGT_OTHER, 8'h55, 1'b0, 1'b0);
		drv(1'b1, TGT_KEY, KEY_SECOND, 1'b0, 1'b0);
		drv(1'b1, TGT_CTRL, 8'h07, 1'b0, 1'b0);
		idle();
		chk(8'h00, {7'h00, core_stall});
		chk(8'h06, ctrl_rd);
	endtask : t_order

	// Reset in mid-operation, then a late completion from the array
	task automatic t_reset;
		busy = 8'h14;
		drv(1'b1, TGT_CTRL, 8'h02, 1'b0, 1'b0);
		drv(1'b1, TGT_KEY, KEY_FIRST, 1'b0, 1'b0);
		drv(1'b1, TGT_KEY, KEY_SECOND, 1'b0, 1'b0);
		drv(1'b1, TGT_CTRL, 8'h07, 1'b0, 1'b0);
		repeat (2) idle();
		chk(8'h01, {7'h00, core_stall});
		arst_n = 1'b0;
		repeat (2) idle();
		chk(8'h00, {6'h00, core_stall, flash_start});
		chk(8'h00, ctrl_rd);
		arst_n = 1'b1;
		repeat (24) idle();
		chk(8'h00, {7'h00, core_stall});
		chk(8'h00, ctrl_rd);
	endtask : t_reset

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(negedge sys_clk);
		chk(8'h00, ctrl_rd);
		chk(8'h00, {6'h00, core_stall, flash_start});
		arst_n = 1'b1;
		t_ops();
		unlock(2'h1, 2, 1'b0, 1'b1, 1'b0);
		unlock(2'h2, 1, 1'b1, 1'b1, 1'b0);
		unlock(2'h3, 0, 1'b0, 1'b0, 1'b0);
		t_order();
		t_reset();
		end_sim();
	end

	// Cuts a hang short well after the expected run of under two hundred cycles
	initial begin
		#80000;
		bad_count++;
		end_sim();
	end
endmodule : nvm_unlock_sequencer_tb
